// ---- hw/timer_and_interrupt_sources.sv ----
// free-running microsecond timer and vectored interrupt sources over apb
// Notes on behaviour
// - twelve-bit counter advances once per microsecond
// - timer sources from bits six and nine
// - timer request only on rising bit
// - low byte read latches upper nibble
// - upper nibble read returns latched value
// - eleven maskable sources, one vector each
// - endpoint requests on receive and send
// - sink port has per-pin mask
// - gpio port has per-input mask
// - sink pin edge chosen per pin
// - gpio edge chosen per port
// - polarity selects rising or falling edge
// - all gpio pins share one vector
// - any enabled sink pin raises sink interrupt
// - writing one disables sink, pin pulled
`include "tmr_irq_cfg.svh"
`default_nettype none
module timer_and_interrupt_sources
    import tmr_irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] ep_rx_done, // endpoint got data from host, pulse
    input wire logic [4:0] ep_tx_done, // endpoint sent packet to host, pulse
    input wire logic hub_event, // hub event pulse
    input wire logic i2c_event, // i2c master event pulse
    input wire logic [7:0] sink_pin_in, // sink-current port pins (async)
    input wire logic [31:0] gpio_pin_in, // four 8-bit gpio ports (async)
    output logic [7:0] sink_out, // 1: sink off, pulled high
    output logic irq,
    output logic [3:0] irq_vector
);

// ----------------------------------------------------------------
// apb access decode
// ----------------------------------------------------------------
logic wr_en; // write takes effect
logic rd_en; // read request in its setup cycle
assign wr_en = psel & penable & pwrite;
assign rd_en = psel & ~penable & ~pwrite;

// ----------------------------------------------------------------
// microsecond tick and free-running counter
// ----------------------------------------------------------------
localparam int TICK_N = `TICK_CYCLES;
logic [6:0] tick_cnt_reg; // divides pclk down to 1 MHz
logic tick; // one-cycle microsecond strobe
count_t count_reg; // live timer
logic [3:0] hi_hold_reg; // latched upper nibble
assign tick = (tick_cnt_reg == 7'(TICK_N - 1));

// divider for the 1 MHz tick
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt_reg <= 7'h00;
    end else if (tick) begin
        tick_cnt_reg <= 7'h00;
    end else begin
        tick_cnt_reg <= tick_cnt_reg + 7'h01;
    end
end

// counter never stops or reloads, wraps naturally
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        count_reg <= 12'h000;
    end else if (tick) begin
        count_reg <= count_reg + 12'h001;
    end
end

// capture upper nibble at the edge that loads the low byte into prdata,
// so a carry between setup and access cannot split the pair
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        hi_hold_reg <= 4'h0;
    end else if (rd_en && paddr == `OFF_TMR_LO) begin
        hi_hold_reg <= count_reg[11:8];
    end
end

// ----------------------------------------------------------------
// timer tap edge detection
// ----------------------------------------------------------------
logic t6_prev_reg; // previous bit 6
logic t9_prev_reg; // previous bit 9
logic t6_rise; // bit 6 low to high
logic t9_rise; // bit 9 low to high
assign t6_rise = count_reg[`TAP_128US_BIT] & ~t6_prev_reg;
assign t9_rise = count_reg[`TAP_1MS_BIT] & ~t9_prev_reg;

// remember tap bits for edge detection
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        t6_prev_reg <= 1'b0;
        t9_prev_reg <= 1'b0;
    end else begin
        t6_prev_reg <= count_reg[`TAP_128US_BIT];
        t9_prev_reg <= count_reg[`TAP_1MS_BIT];
    end
end

// ----------------------------------------------------------------
// pin synchronisers and edge detection
// ----------------------------------------------------------------
logic [7:0] sink_m_reg; // first stage, read only by second
logic [7:0] sink_s_reg; // synchronised sink pins
logic [7:0] sink_p_reg; // previous synchronised value
logic [31:0] gpio_m_reg; // first stage
logic [31:0] gpio_s_reg; // synchronised gpio pins
logic [31:0] gpio_p_reg; // previous value
logic [7:0] sink_mask_reg; // per-pin sink enable
logic [7:0] sink_pol_reg; // per-pin edge, 1 rising
logic [31:0] gpio_mask_reg; // per-input gpio enable
logic [3:0] gpio_pol_reg; // per-port edge, 1 rising
logic [7:0] sink_hit; // qualified sink pin edges
logic [31:0] gpio_hit; // qualified gpio pin edges

// two flip-flop synchronisers and history
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sink_m_reg <= 8'hFF;
        sink_s_reg <= 8'hFF;
        sink_p_reg <= 8'hFF;
        gpio_m_reg <= 32'hFFFFFFFF;
        gpio_s_reg <= 32'hFFFFFFFF;
        gpio_p_reg <= 32'hFFFFFFFF;
    end else begin
        sink_m_reg <= sink_pin_in;
        sink_s_reg <= sink_m_reg;
        sink_p_reg <= sink_s_reg;
        gpio_m_reg <= gpio_pin_in;
        gpio_s_reg <= gpio_m_reg;
        gpio_p_reg <= gpio_s_reg;
    end
end

genvar gi;
generate
    for (gi = 0; gi < 8; gi++) begin : g_sink
        // per-pin polarity picks rising or falling
        assign sink_hit[gi] = sink_mask_reg[gi] & (sink_pol_reg[gi] ?
            (sink_s_reg[gi] & ~sink_p_reg[gi]) :
            (~sink_s_reg[gi] & sink_p_reg[gi]));
    end
    for (gi = 0; gi < 32; gi++) begin : g_gpio
        // polarity comes from the pin's port
        assign gpio_hit[gi] = gpio_mask_reg[gi] & (gpio_pol_reg[gi / 8] ?
            (gpio_s_reg[gi] & ~gpio_p_reg[gi]) :
            (~gpio_s_reg[gi] & gpio_p_reg[gi]));
    end
endgenerate

// ----------------------------------------------------------------
// interrupt sources, pending and vectors
// ----------------------------------------------------------------
src_t event_vec; // raw event per source
src_t pend_reg; // sticky pending status
src_t en_reg; // main enable mask
src_t pend_clr; // write-one-to-clear and vector ack
src_t active; // pending and enabled
vec_t vec_next; // lowest active source

assign event_vec[`SRC_T128] = t6_rise;
assign event_vec[`SRC_T1MS] = t9_rise;
assign event_vec[`SRC_EP0 +: `NUM_EP] = ep_rx_done | ep_tx_done;
assign event_vec[`SRC_HUB] = hub_event;
assign event_vec[`SRC_SINK] = |sink_hit;
assign event_vec[`SRC_GPIO] = |gpio_hit;
assign event_vec[`SRC_I2C] = i2c_event;
assign active = pend_reg & en_reg;

// clear sources: status write of ones, or ack of current vector
always_comb begin
    pend_clr = '0;
    if (wr_en && paddr == `OFF_IRQ_STAT) begin
        pend_clr = pwdata[10:0];
    end else if (wr_en && paddr == `OFF_VEC_ACK && irq) begin
        pend_clr[irq_vector] = 1'b1;
    end
end

// sticky pending, a new event wins over a clear
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pend_reg <= '0;
    end else begin
        pend_reg <= (pend_reg & ~pend_clr) | event_vec;
    end
end

// priority encode: lowest source number first
always_comb begin
    vec_next = 4'h0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
        if (active[i]) begin
            vec_next = 4'(i);
        end
    end
end

// registered interrupt outputs
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq <= 1'b0;
        irq_vector <= 4'h0;
    end else begin
        irq <= |active;
        irq_vector <= vec_next;
    end
end

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
// configuration writes
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        en_reg <= '0;
        sink_mask_reg <= 8'h00;
        sink_pol_reg <= 8'h00;
        gpio_mask_reg <= 32'h00000000;
        gpio_pol_reg <= 4'h0;
        sink_out <= `RST_SINK_OUT;
    end else if (wr_en) begin
        unique case (paddr)
            `OFF_IRQ_EN: en_reg <= pwdata[10:0];
            `OFF_SINK_MASK: sink_mask_reg <= pwdata[7:0];
            `OFF_SINK_POL: sink_pol_reg <= pwdata[7:0];
            `OFF_SINK_OUT: sink_out <= pwdata[7:0];
            `OFF_GPIO_MASK: gpio_mask_reg <= pwdata;
            `OFF_GPIO_POL: gpio_pol_reg <= pwdata[3:0];
            default: ;
        endcase
    end
end

// read data, zero-wait answer, error on unmapped
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & ~penable;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (psel && !penable) begin
            unique case (paddr)
                `OFF_TMR_LO: prdata <= {24'h000000, count_reg[7:0]};
                `OFF_TMR_HI: prdata <= {28'h0000000, hi_hold_reg};
                `OFF_IRQ_STAT: prdata <= {21'h0, pend_reg};
                `OFF_IRQ_EN: prdata <= {21'h0, en_reg};
                `OFF_SINK_MASK: prdata <= {24'h000000, sink_mask_reg};
                `OFF_SINK_POL: prdata <= {24'h000000, sink_pol_reg};
                `OFF_SINK_OUT: prdata <= {24'h000000, sink_s_reg};
                `OFF_GPIO_MASK: prdata <= gpio_mask_reg;
                `OFF_GPIO_POL: prdata <= {28'h0000000, gpio_pol_reg};
                `OFF_VECTOR: prdata <= {27'h0, irq, irq_vector};
                `OFF_VEC_ACK: prdata <= 32'h00000000;
                default: pslverr <= 1'b1;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> count_reg == $past(count_reg) + 12'h001)
    else $error("timer did not advance on tick");
chk_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !tick |=> $stable(count_reg))
    else $error("timer moved without tick");
chk_t6_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(count_reg[6]) |=> pend_reg[0])
    else $error("bit 6 rise not pending");
chk_t6_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(count_reg[6]) && !pend_reg[0] |=> !pend_reg[0])
    else $error("bit 6 fall raised request");
chk_hi_latch: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == `OFF_TMR_LO |=> hi_hold_reg == $past(count_reg[11:8]))
    else $error("upper nibble not latched");
chk_pend_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    pend_reg[9] && !pend_clr[9] |=> pend_reg[9])
    else $error("pending bit lost");
chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    |active |=> irq)
    else $error("active source without irq");
chk_sink_mask: assert property (@(posedge pclk) disable iff (!presetn)
    sink_mask_reg == 8'h00 |-> !event_vec[8])
    else $error("masked sink pin raised event");
chk_gpio_mask: assert property (@(posedge pclk) disable iff (!presetn)
    gpio_mask_reg == 32'h00000000 |-> !event_vec[9])
    else $error("masked gpio pin raised event");
chk_sink_out: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `OFF_SINK_OUT |=> sink_out == $past(pwdata[7:0]))
    else $error("sink output not written");
// timer tap and latch checks
chk_t9_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(count_reg[9]) |=> pend_reg[1])
    else $error("bit 9 rise not pending");
chk_hi_return: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == `OFF_TMR_HI |=> prdata[3:0] == $past(hi_hold_reg))
    else $error("upper nibble read not from latch");
// event path checks
chk_ep_event: assert property (@(posedge pclk) disable iff (!presetn)
    (ep_rx_done | ep_tx_done) != 5'h00 |=>
    (pend_reg[6:2] & $past(ep_rx_done | ep_tx_done)) == $past(ep_rx_done | ep_tx_done))
    else $error("endpoint event not pending");
chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    event_vec[7] |=> pend_reg[7])
    else $error("event lost against clear");
chk_vec_lowest: assert property (@(posedge pclk) disable iff (!presetn)
    pend_reg[0] && en_reg[0] |=> irq_vector == 4'h0)
    else $error("vector not lowest active source");
chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    active == 11'h000 |=> !irq)
    else $error("irq without active source");
// pin path checks
chk_sink_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (sink_mask_reg & sink_pol_reg & sink_s_reg & ~sink_p_reg) != 8'h00 |=> pend_reg[8])
    else $error("sink rising edge not pending");
chk_sink_fall: assert property (@(posedge pclk) disable iff (!presetn)
    (sink_mask_reg & ~sink_pol_reg & ~sink_s_reg & sink_p_reg) != 8'h00 |=> pend_reg[8])
    else $error("sink falling edge not pending");
chk_gpio_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (gpio_mask_reg[15:8] & gpio_s_reg[15:8] & ~gpio_p_reg[15:8]) != 8'h00 &&
    gpio_pol_reg[1] |=> pend_reg[9])
    else $error("gpio rising edge not pending");
chk_gpio_fall: assert property (@(posedge pclk) disable iff (!presetn)
    (gpio_mask_reg[31:24] & ~gpio_s_reg[31:24] & gpio_p_reg[31:24]) != 8'h00 &&
    !gpio_pol_reg[3] |=> pend_reg[9])
    else $error("gpio falling edge not pending");

endmodule
`default_nettype wire

// ---- hw/tmr_irq_cfg.svh ----
// timer and interrupt block constants: offsets, field positions, reset values
`ifndef TMR_IRQ_CFG_SVH
`define TMR_IRQ_CFG_SVH
// tick derivation
`define TICK_PERIOD_NS 1000
`define CLK_PERIOD_NS 10
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// timer taps
`define TAP_128US_BIT 6
`define TAP_1MS_BIT 9
// interrupt source indices
`define SRC_T128 0
`define SRC_T1MS 1
`define SRC_EP0 2
`define SRC_HUB 7
`define SRC_SINK 8
`define SRC_GPIO 9
`define SRC_I2C 10
`define NUM_SRC 11
`define NUM_EP 5
// register byte offsets
`define OFF_TMR_LO 12'h000
`define OFF_TMR_HI 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_EN 12'h00C
`define OFF_SINK_MASK 12'h010
`define OFF_SINK_POL 12'h014
`define OFF_SINK_OUT 12'h018
`define OFF_GPIO_MASK 12'h01C
`define OFF_GPIO_POL 12'h020
`define OFF_VECTOR 12'h024
`define OFF_VEC_ACK 12'h028
// reset values
`define RST_SINK_OUT 8'hFF
`endif

// ---- hw/tmr_irq_pkg.sv ----
// types shared by the timer and interrupt block
`default_nettype none
package tmr_irq_pkg;
    typedef logic [11:0] count_t; // timer value
    typedef logic [10:0] src_t; // one bit per interrupt source
    typedef logic [3:0] vec_t; // vector number
endpackage
`default_nettype wire

// ---- verif/cpu_core_model.sv ----
// processor-side model: apb master through which firmware accesses run
`default_nettype none
module cpu_core_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // bus idle at time zero
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // one transfer: setup cycle, access held until pready, then one idle edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the bench watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ---- verif/timer_and_interrupt_sources_tb_top.sv ----
// self-checking bench for the timer and interrupt block
`include "tmr_irq_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
end
module timer_and_interrupt_sources_tb_top import tmr_irq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and scoreboard
    // ----------------------------------------
    typedef struct {logic [11:0] a; logic [31:0] m; logic [32:0] e;} note_s;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, gpio_pin_in = 32'hFFFFFFFF, seed = 32'h2065FF44;
    logic [4:0] ep_rx_done = '0, ep_tx_done = '0; // endpoint event pulses
    logic hub_event = 1'b0, i2c_event = 1'b0;
    logic [7:0] sink_pin_in = 8'hFF, sink_out; // pins idle high on their pull-ups
    vec_t irq_vector;
    int fails = 0, samples_checked = 0, cyc = 0, k, src;
    note_s notes[$]; // expected read results, oldest first
    note_s nt;
    always #5 pclk = ~pclk;
    timer_and_interrupt_sources u_timer_and_interrupt_sources (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ep_rx_done(ep_rx_done),
        .ep_tx_done(ep_tx_done), .hub_event(hub_event), .i2c_event(i2c_event),
        .sink_pin_in(sink_pin_in), .gpio_pin_in(gpio_pin_in), .sink_out(sink_out),
        .irq(irq), .irq_vector(irq_vector));
    cpu_core_model u_cpu_core_model (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready));
    // bus monitor: every completed read is compared with the oldest note
    always @(posedge pclk) begin
        if (presetn)
            cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                fails++;
                $display("[ERR] read %0h exp none got %0h", paddr, prdata);
            end else begin
                nt = notes.pop_front();
                `CHK($sformatf("read %0h", nt.a), nt.e, {pslverr, prdata & nt.m})
            end
        end
    end
    // ----------------------------------------
    // helper tasks
    // ----------------------------------------
    task automatic rd(input logic [11:0] a, input logic [31:0] m, e, input logic err);
        notes.push_back('{a, m, {err, e}});
        u_cpu_core_model.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_cpu_core_model.xfer(1'b1, a, d);
    endtask
    task automatic till(input int c);
        while (cyc < c) @(posedge pclk);
    endtask
    // drive pins, let the synchroniser settle, check one pending bit, clear all
    task automatic pins(input logic [7:0] s, input logic [31:0] g, input int n, input logic hit);
        sink_pin_in <= s;
        gpio_pin_in <= g;
        repeat (8) @(posedge pclk);
        rd(`OFF_IRQ_STAT, 32'h1 << n, {31'h0, hit} << n, 1'b0);
        wr(`OFF_IRQ_STAT, 32'h7FF);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog: tests need about 52000 cycles
    initial begin
        #700000;
        fails++;
        test_done();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("sink_out", 8'hFF, sink_out)
        `CHK("irq", 1'b0, irq)
        wr(`OFF_IRQ_EN, 32'h7FF);
        // endpoint, hub and i2c sources in turn: pending, vector, acknowledge
        for (k = 0; k < 12; k++) begin
            src = (k < 10) ? 2 + k / 2 : (k == 10) ? `SRC_HUB : `SRC_I2C;
            if (k < 10 && k % 2 == 0) ep_rx_done[k / 2] <= 1'b1;
            else if (k < 10) ep_tx_done[k / 2] <= 1'b1;
            else if (k == 10) hub_event <= 1'b1;
            else i2c_event <= 1'b1;
            @(posedge pclk);
            {ep_rx_done, ep_tx_done, hub_event, i2c_event} <= '0;
            repeat (3) @(posedge pclk);
            `CHK("irq", 1'b1, irq)
            `CHK("irq_vector", src[3:0], irq_vector)
            rd(`OFF_IRQ_STAT, 32'h7FF, 32'h1 << src, 1'b0);
            rd(`OFF_VECTOR, 32'h1F, 32'h10 | src, 1'b0);
            wr(`OFF_VEC_ACK, 32'h0);
            repeat (2) @(posedge pclk);
            `CHK("irq", 1'b0, irq)
        end
        // disabled source stays pending without raising irq
        wr(`OFF_IRQ_EN, 32'h0);
        hub_event <= 1'b1;
        @(posedge pclk);
        hub_event <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        rd(`OFF_IRQ_STAT, 32'h7FF, 32'h1 << `SRC_HUB, 1'b0);
        wr(`OFF_IRQ_EN, 32'h7FF);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        wr(`OFF_IRQ_STAT, 32'h1 << `SRC_HUB);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        $display("test done: events and masking");
        // pin edges: sink pin0 rising, pin1 falling, gpio port1 rising
        wr(`OFF_SINK_MASK, 32'h03);
        wr(`OFF_SINK_POL, 32'h01);
        wr(`OFF_GPIO_MASK, 32'h01000100);
        wr(`OFF_GPIO_POL, 32'h2);
        pins(8'hFE, '1, `SRC_SINK, 1'b0);
        pins(8'hFF, '1, `SRC_SINK, 1'b1);
        pins(8'hFD, '1, `SRC_SINK, 1'b1);
        pins(8'hF9, '1, `SRC_SINK, 1'b0);
        pins(8'hFF, 32'hFFFFFEFF, `SRC_GPIO, 1'b0);
        pins(8'hFF, 32'hFFFFFFFF, `SRC_GPIO, 1'b1);
        repeat (3) begin
            seed = xs(seed);
            pins(8'hFF, seed | 32'h01000100, `SRC_GPIO, 1'b0);
        end
        pins(8'hFF, 32'hFEFFFFFF, `SRC_GPIO, 1'b1);
        wr(`OFF_GPIO_POL, 32'h0);
        pins(8'hFF, 32'hFEFFFEFF, `SRC_GPIO, 1'b1);
        wr(`OFF_SINK_OUT, 32'h5A);
        @(posedge pclk);
        `CHK("sink_out", 8'h5A, sink_out)
        rd(12'h100, 32'hFFFFFFFF, 32'h0, 1'b1);
        $display("test done: pins and sink port");
        // timer taps and the upper nibble latch
        wr(`OFF_IRQ_STAT, 32'h7FF);
        till(6350);
        rd(`OFF_IRQ_STAT, 32'h3, 32'h0, 1'b0);
        till(6450);
        rd(`OFF_IRQ_STAT, 32'h3, 32'h1, 1'b0);
        rd(`OFF_VECTOR, 32'h1F, 32'h10, 1'b0);
        wr(`OFF_IRQ_STAT, 32'h7FF);
        till(12900);
        rd(`OFF_IRQ_STAT, 32'h3, 32'h0, 1'b0);
        till(25550);
        rd(`OFF_TMR_LO, 32'hFF, 32'hFF, 1'b0);
        till(26050);
        rd(`OFF_TMR_HI, 32'hF, 32'h0, 1'b0);
        rd(`OFF_TMR_LO, 32'hFF, 32'h04, 1'b0);
        rd(`OFF_TMR_HI, 32'hF, 32'h1, 1'b0);
        wr(`OFF_IRQ_STAT, 32'h7FF);
        till(51150);
        rd(`OFF_IRQ_STAT, 32'h2, 32'h0, 1'b0);
        till(51250);
        rd(`OFF_IRQ_STAT, 32'h2, 32'h2, 1'b0);
        $display("test done: timer");
        test_done();
    end
endmodule
`default_nettype wire
